// ===== design/sercore_cfg.svh
// register map, field positions, reset values and timing counts of the core control registers
// assumes a 100 MHz core clock; included by bare name from both design module files
`ifndef SERCORE_CFG_SVH
`define SERCORE_CFG_SVH

`define REG_BUS_IDENTITY 8'h00
`define REG_RESET_CONTROL 8'h01
`define REG_GENERAL_CONFIGURATION 8'h02
`define REG_EVENT_STATUS 8'hF0
`define READ_UNMAPPED 8'h00

`define ID_OVERRIDE_BIT 0
`define RST_LOGIC_BIT 0
`define RST_FULL_BIT 1
`define RST_RELOAD_BIT 2
`define RST_SPARE_MSB 7
`define RST_SPARE_LSB 3

// four lanes, crc on, continuous clock off; bit 0 comes from the strap
`define GEN_RESET_VALUE 8'h32
`define RST_SPARE_RESET 5'h00
`define EVT_HIGH_RESET 4'h0
`define EVT_LOW_RESET 4'hF

`define CLK_PERIOD_NS 10
`define SOFT_RESET_TIME_NS 100
`define SOFT_RESET_CYCLES ((`SOFT_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define STRAP_CAPTURE_CYCLE 2'h2
`define STRAP_DONE_CYCLE 2'h3
`define I2C_BYTE_BITS 4'h8
`define SCL_IDLE 3'h7
`define SDA_IDLE 3'h7

`endif

// ===== design/sercore_pkg.sv
// types shared by the core control register block and its reset sequencer
// constants live in sercore_cfg.svh; this package holds types only
package sercore_pkg;

   typedef struct packed {
      logic reserved_7;
      logic clock_lane_continuous;
      logic [1:0] data_lane_sel;
      logic [1:0] reserved_3_2;
      logic crc_tx_enable;
      logic bus_voltage_1v8;
   } general_cfg_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_access_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } remote_req_t;

   typedef enum logic [3:0] {
      st_idle,
      st_addr,
      st_addr_ack,
      st_index,
      st_index_ack,
      st_write,
      st_write_ack,
      st_read,
      st_read_ack
   } i2c_state_t;

endpackage

// ===== design/reset_sequencer.sv
// soft reset and rom reload sequencer for the core control registers
// assumes one-cycle request pulses on i_core_clk and a done pulse from the rom loader
`timescale 1ns/1ps
`include "sercore_cfg.svh"

module reset_sequencer #(
   parameter int RESET_CYCLES = `SOFT_RESET_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_logic_reset_req,
   input wire logic i_full_reset_req,
   input wire logic i_reload_req,
   input wire logic i_reload_done,
   output logic o_logic_reset,
   output logic o_reg_reset,
   output logic o_reload_start,
   output logic [2:0] o_busy
);
   import sercore_pkg::*;

   localparam int CW = $clog2(RESET_CYCLES + 1);

   generate
      if (RESET_CYCLES < 1) begin : g_bad_cycles
         $error("reset_sequencer: RESET_CYCLES must be at least 1");
      end
   endgenerate

   logic rst_busy_q;
   logic rst_full_q;
   logic [CW-1:0] rst_cnt_q;
   logic reload_busy_q;
   logic reload_start_q;
   logic rst_req;

   assign rst_req = i_logic_reset_req | i_full_reset_req;

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         rst_busy_q <= 1'b0;
         rst_full_q <= 1'b0;
         rst_cnt_q <= '0;
      end else if (rst_req && !rst_busy_q) begin
         rst_busy_q <= 1'b1;
         rst_full_q <= i_full_reset_req;
         rst_cnt_q <= CW'(RESET_CYCLES - 1);
      end else if (rst_busy_q) begin
         if (rst_cnt_q == '0) begin
            rst_busy_q <= 1'b0;
         end else begin
            rst_cnt_q <= rst_cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         reload_busy_q <= 1'b0;
         reload_start_q <= 1'b0;
      end else begin
         reload_start_q <= i_reload_req && !reload_busy_q;
         if (i_reload_req && !reload_busy_q) begin
            reload_busy_q <= 1'b1;
         end else if (i_reload_done && !reload_start_q) begin
            reload_busy_q <= 1'b0;
         end
      end
   end

   assign o_logic_reset = rst_busy_q;
   assign o_reg_reset = rst_busy_q & rst_full_q;
   assign o_reload_start = reload_start_q;
   assign o_busy = {reload_busy_q, rst_busy_q & rst_full_q, rst_busy_q & ~rst_full_q};

endmodule

// ===== design/serializer_core_control_regs.sv
// core control registers of the serializer behind its two-wire control port
// assumes scl/sda and strap pins are asynchronous; remote back-channel and event inputs are on i_core_clk
`timescale 1ns/1ps
`include "sercore_cfg.svh"

// Behaviour
// - read-to-clear fields return their value, then clear because of that read.
// - self-clearing bits take a written one, act, then return to zero alone.
// - latched status bits capture their condition and hold it until read.
// - strap fields load from sampled configuration pins at start-up, not constants.
// - identity register shows identity in use; field writable only with override set.
// - target answers strapped identity, or programmed identity once override is one.
// - reset control bit 2 restarts the rom auto-load, then self-clears.
// - reset control bit 1 resets all logic and registers, then self-clears.
// - reset control bit 0 resets logic but keeps registers, then self-clears.
// - general bit 6 selects continuous clock lane; default non-continuous.
// - general bits 5:4 select one, two or four lanes; default four.
// - general bit 1 enables transmit crc; enabled after reset.
// - general bit 0 shows strapped bus voltage; one is 1.8 V, writable.
module serializer_core_control_regs #(
   parameter int RESET_CYCLES = `SOFT_RESET_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire sercore_pkg::remote_req_t i_remote,
   output logic o_remote_ack,
   output logic [7:0] o_remote_rdata,
   input wire logic [6:0] i_identity_strap,
   input wire logic i_address_strap_pin,
   input wire logic [3:0] i_event_high,
   input wire logic [3:0] i_event_low,
   input wire logic i_rom_reload_done,
   output logic o_rom_reload_start,
   output logic o_logic_reset,
   output logic [6:0] o_bus_identity,
   output sercore_pkg::general_cfg_t o_general_cfg
);
   import sercore_pkg::*;

   // pin synchronisers; index 0 is read only by index 1
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   logic [6:0] strap_id_s1_q;
   logic [6:0] strap_id_s2_q;
   logic [6:0] strap_id_hold_q;
   logic strap_volt_s1_q;
   logic strap_volt_s2_q;
   logic strap_volt_hold_q;
   logic [1:0] strap_cnt_q;
   logic strap_capture;

   // two-wire target
   i2c_state_t state_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [7:0] index_q;
   logic rw_q;
   logic sda_oe_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic sda_bit;
   logic byte_done;
   logic addr_match;
   logic in_ack;
   logic loc_wr;
   logic loc_rd;
   logic local_busy;

   // register file
   reg_access_t acc;
   logic id_override_q;
   logic [6:0] prog_id_q;
   logic [4:0] rst_spare_q;
   general_cfg_t gen_q;
   logic [3:0] evt_high_q;
   logic [3:0] evt_low_q;
   logic [7:0] remote_rdata_q;
   logic [6:0] active_id;
   logic [7:0] rd_data;
   logic hit_id;
   logic hit_rst;
   logic hit_gen;
   logic hit_evt;
   logic wr_id;
   logic wr_rst;
   logic wr_gen;
   logic rd_evt;
   logic reg_clear;
   logic reg_reset;
   logic [2:0] seq_busy;

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         scl_q <= `SCL_IDLE;
         sda_q <= `SDA_IDLE;
      end else begin
         scl_q <= {scl_q[1:0], i_scl};
         sda_q <= {sda_q[1:0], i_sda};
      end
   end

   always_ff @(posedge i_core_clk) begin
      strap_id_s1_q <= i_identity_strap;
      strap_id_s2_q <= strap_id_s1_q;
      strap_volt_s1_q <= i_address_strap_pin;
      strap_volt_s2_q <= strap_volt_s1_q;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         strap_cnt_q <= 2'h0;
         strap_id_hold_q <= 7'h00;
         strap_volt_hold_q <= 1'b0;
      end else begin
         if (strap_cnt_q != `STRAP_DONE_CYCLE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
         if (strap_capture) begin
            strap_id_hold_q <= strap_id_s2_q;
            strap_volt_hold_q <= strap_volt_s2_q;
         end
      end
   end

   // capture waits two cycles so the synchronisers hold pin levels, not reset leftovers
   assign strap_capture = (strap_cnt_q == `STRAP_CAPTURE_CYCLE);

   assign scl_rise = scl_q[1] & ~scl_q[2];
   assign scl_fall = ~scl_q[1] & scl_q[2];
   assign bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign bus_stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
   assign sda_bit = sda_q[1];
   assign byte_done = scl_fall && (bit_cnt_q == `I2C_BYTE_BITS);
   assign addr_match = (shift_q[7:1] == active_id);
   assign in_ack = (state_q == st_addr_ack) || (state_q == st_read_ack);
   assign loc_wr = (state_q == st_write) && byte_done;
   assign loc_rd = scl_fall && in_ack && ((state_q == st_read_ack) || rw_q);
   assign local_busy = loc_wr | loc_rd;

   always_ff @(posedge i_core_clk) begin
      if (i_reset || bus_stop) begin
         state_q <= st_idle;
         sda_oe_q <= 1'b0;
         bit_cnt_q <= 4'h0;
      end else if (bus_start) begin
         state_q <= st_addr;
         sda_oe_q <= 1'b0;
         bit_cnt_q <= 4'h0;
      end else begin
         unique case (state_q)
            st_idle: begin
            end
            st_addr, st_index, st_write: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_bit};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_q <= 4'h0;
                  if (state_q == st_addr) begin
                     rw_q <= shift_q[0];
                     sda_oe_q <= addr_match;
                     state_q <= addr_match ? st_addr_ack : st_idle;
                  end else if (state_q == st_index) begin
                     index_q <= shift_q;
                     sda_oe_q <= 1'b1;
                     state_q <= st_index_ack;
                  end else begin
                     index_q <= index_q + 8'h01;
                     sda_oe_q <= 1'b1;
                     state_q <= st_write_ack;
                  end
               end
            end
            st_addr_ack, st_index_ack, st_write_ack, st_read_ack: begin
               if (scl_rise && (state_q == st_read_ack) && sda_bit) begin
                  state_q <= st_idle;
               end else if (scl_fall) begin
                  if (loc_rd) begin
                     shift_q <= rd_data;
                     sda_oe_q <= ~rd_data[7];
                     index_q <= index_q + 8'h01;
                     state_q <= st_read;
                  end else begin
                     sda_oe_q <= 1'b0;
                     state_q <= (state_q == st_addr_ack) ? st_index : st_write;
                  end
               end
            end
            st_read: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_q <= 4'h0;
                  sda_oe_q <= 1'b0;
                  state_q <= st_read_ack;
               end else if (scl_fall) begin
                  shift_q <= {shift_q[6:0], 1'b0};
                  sda_oe_q <= ~shift_q[6];
               end
            end
         endcase
      end
   end

   assign o_sda = 1'b0;
   assign o_sda_oe = sda_oe_q;

   // local accesses land on fixed scl edges and cannot wait, so the remote side yields
   assign o_remote_ack = i_remote.req & ~local_busy;
   assign acc.wr = loc_wr | (o_remote_ack & i_remote.write);
   assign acc.rd = loc_rd | (o_remote_ack & ~i_remote.write);
   assign acc.addr = local_busy ? index_q : i_remote.addr;
   assign acc.data = local_busy ? shift_q : i_remote.wdata;

   assign hit_id = (acc.addr == `REG_BUS_IDENTITY);
   assign hit_rst = (acc.addr == `REG_RESET_CONTROL);
   assign hit_gen = (acc.addr == `REG_GENERAL_CONFIGURATION);
   assign hit_evt = (acc.addr == `REG_EVENT_STATUS);
   assign wr_id = acc.wr & hit_id;
   assign wr_rst = acc.wr & hit_rst;
   assign wr_gen = acc.wr & hit_gen;
   assign rd_evt = acc.rd & hit_evt;

   assign active_id = id_override_q ? prog_id_q : strap_id_hold_q;

   assign rd_data = hit_id ? {active_id, id_override_q} :
                    hit_rst ? {rst_spare_q, seq_busy} :
                    hit_gen ? gen_q :
                    hit_evt ? {evt_low_q, evt_high_q} :
                    `READ_UNMAPPED;

   assign reg_clear = i_reset | reg_reset;

   always_ff @(posedge i_core_clk) begin
      if (reg_clear) begin
         id_override_q <= 1'b0;
         prog_id_q <= 7'h00;
         rst_spare_q <= `RST_SPARE_RESET;
         gen_q <= `GEN_RESET_VALUE;
         gen_q.bus_voltage_1v8 <= strap_volt_hold_q & ~i_reset;
      end else begin
         if (strap_capture) begin
            gen_q.bus_voltage_1v8 <= strap_volt_s2_q;
         end
         if (wr_id) begin
            id_override_q <= acc.data[`ID_OVERRIDE_BIT];
            if (acc.data[`ID_OVERRIDE_BIT]) begin
               prog_id_q <= acc.data[7:1];
            end
         end
         if (wr_rst) begin
            rst_spare_q <= acc.data[`RST_SPARE_MSB:`RST_SPARE_LSB];
         end
         if (wr_gen) begin
            gen_q <= acc.data;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (reg_clear) begin
         evt_high_q <= `EVT_HIGH_RESET;
         evt_low_q <= `EVT_LOW_RESET;
      end else begin
         evt_high_q <= (evt_high_q & ~{4{rd_evt}}) | i_event_high;
         evt_low_q <= (evt_low_q | {4{rd_evt}}) & i_event_low;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         remote_rdata_q <= 8'h00;
      end else if (o_remote_ack && !i_remote.write) begin
         remote_rdata_q <= rd_data;
      end
   end

   reset_sequencer #(
      .RESET_CYCLES(RESET_CYCLES)
   ) u_reset_sequencer (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_logic_reset_req(wr_rst & acc.data[`RST_LOGIC_BIT]),
      .i_full_reset_req(wr_rst & acc.data[`RST_FULL_BIT]),
      .i_reload_req(wr_rst & acc.data[`RST_RELOAD_BIT]),
      .i_reload_done(i_rom_reload_done),
      .o_logic_reset(o_logic_reset),
      .o_reg_reset(reg_reset),
      .o_reload_start(o_rom_reload_start),
      .o_busy(seq_busy)
   );

   assign o_remote_rdata = remote_rdata_q;
   assign o_bus_identity = active_id;
   assign o_general_cfg = gen_q;

endmodule

// ===== tb/serializer_core_control_regs_asserts.sv
// port assertions for the core control registers
// bound from the testbench top; one clock domain
`timescale 1ns/1ps
module serializer_core_control_regs_asserts #(
   parameter int RESET_CYCLES = 10
) (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire sercore_pkg::remote_req_t i_remote,
   input wire logic o_remote_ack,
   input wire logic [7:0] o_remote_rdata,
   input wire logic o_rom_reload_start,
   input wire logic o_logic_reset,
   input wire logic [6:0] o_bus_identity,
   input wire sercore_pkg::general_cfg_t o_general_cfg,
   input wire logic o_sda_oe
);
   import sercore_pkg::*;
   logic [7:0] rst_len_q;
   wire rw = o_remote_ack && i_remote.write && !o_logic_reset;
   wire rd = o_remote_ack && !i_remote.write;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   always_ff @(posedge i_core_clk) begin
      if (i_reset || !o_logic_reset) rst_len_q <= 8'h00;
      else rst_len_q <= rst_len_q + 8'h01;
   end
   chk_cfg_reset_val: assert property ($fell(i_reset) |-> o_general_cfg[7:1] == 7'h19)
      else $error("general config reset value wrong");
   chk_reload_pulse: assert property (rw && i_remote.addr == 8'h01 && i_remote.wdata[2] |=> o_rom_reload_start ##1 !o_rom_reload_start)
      else $error("reload start pulse wrong");
   chk_soft_rst_start: assert property (rw && i_remote.addr == 8'h01 && |i_remote.wdata[1:0] |=> o_logic_reset)
      else $error("logic reset did not start");
   chk_soft_rst_len: assert property ($fell(o_logic_reset) |-> rst_len_q == RESET_CYCLES)
      else $error("logic reset length wrong");
   chk_regs_kept: assert property (rw && i_remote.addr == 8'h01 && i_remote.wdata[1:0] == 2'b01 |=> $stable(o_general_cfg)[*4])
      else $error("registers lost in logic reset");
   chk_full_rst_regs: assert property (rw && i_remote.addr == 8'h01 && i_remote.wdata[1] |-> ##[1:2] o_general_cfg[7:1] == 7'h19)
      else $error("full reset left registers");
   chk_cfg_write: assert property (rw && i_remote.addr == 8'h02 |=> o_general_cfg == $past(i_remote.wdata))
      else $error("general config write lost");
   chk_ident_write: assert property (rw && i_remote.addr == 8'h00 && i_remote.wdata[0] |=> o_bus_identity == $past(i_remote.wdata[7:1]))
      else $error("programmed identity not used");
   chk_ident_read: assert property (rd && i_remote.addr == 8'h00 |=> o_remote_rdata[7:1] == $past(o_bus_identity))
      else $error("identity readback differs");
   chk_cfg_read: assert property (rd && i_remote.addr == 8'h02 |=> o_remote_rdata == $past(o_general_cfg))
      else $error("general config readback differs");
   cover property (o_rom_reload_start);
   cover property ($fell(o_logic_reset));
   cover property (o_sda_oe);
endmodule

// ===== tb/sercore_host_model.sv
// far-side model: two-wire bus controller and back-channel requester
// assumes a pull-up on the data line; ticks are core clock falling edges
`timescale 1ns/1ps
module sercore_host_model (
   input wire logic i_core_clk,
   input wire logic i_sda_oe,
   input wire logic i_remote_ack,
   input wire logic [7:0] i_remote_rdata,
   output logic o_scl,
   output logic o_sda,
   output sercore_pkg::remote_req_t o_remote
);
   import sercore_pkg::*;
   logic sda_q = 1'b1;
   assign o_sda = sda_q & ~i_sda_oe;
   initial begin
      o_scl = 1'b1;
      o_remote = '0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   // also serves as repeated start, since scl is low on entry
   task automatic start;
      sda_q = 1'b1;
      tick(3);
      o_scl = 1'b1;
      tick(3);
      sda_q = 1'b0;
      tick(3);
      o_scl = 1'b0;
      tick(3);
   endtask
   task automatic stop;
      sda_q = 1'b0;
      tick(3);
      o_scl = 1'b1;
      tick(3);
      sda_q = 1'b1;
      tick(3);
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_q = b;
      tick(3);
      o_scl = 1'b1;
      tick(3);
      r = o_sda;
      tick(3);
      o_scl = 1'b0;
      tick(3);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic i2c_wr(input logic [6:0] id, input logic [7:0] idx, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      start;
      xfer({id, 1'b0}, q, a0);
      xfer(idx, q, a1);
      xfer(d, q, a2);
      stop;
      ok = a0 & a1 & a2;
   endtask
   // single byte read; the final nack ends it
   task automatic i2c_rd(input logic [6:0] id, input logic [7:0] idx, output logic [7:0] q, output logic ok);
      logic a0, a1, a2;
      start;
      xfer({id, 1'b0}, q, a0);
      xfer(idx, q, a1);
      start;
      xfer({id, 1'b1}, q, a2);
      xfer(8'hFF, q, a0);
      stop;
      ok = a2;
   endtask
   // request held until ack is seen before the taking edge
   // one idle cycle first keeps back-to-back calls from toggling req in one time step;
   // a request never acked waits here until the bench watchdog ends the run
   task automatic rem(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      tick(1);
      o_remote = '{req: 1'b1, write: w, addr: a, wdata: d};
      #1;
      while (i_remote_ack !== 1'b1) begin
         tick(1);
         #1;
      end
      tick(1);
      o_remote.req = 1'b0;
      q = i_remote_rdata;
   endtask
endmodule

// ===== tb/serializer_core_control_regs_test.sv
// self-checking bench for the core control registers
// far side is the host model; ports are driven on falling edges
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module serializer_core_control_regs_test;
   import sercore_pkg::*;
   localparam logic [6:0] STRAP_ID = 7'h2C;
   localparam int RST_N = 4;
   logic i_core_clk, i_reset, i_rom_reload_done, scl, sda, o_sda, o_sda_oe, ack, o_reload, o_logic_reset, ok;
   logic strap_volt;
   logic [3:0] i_event_high, i_event_low;
   logic [7:0] rdata, q;
   logic [6:0] o_bus_identity;
   general_cfg_t o_general_cfg;
   remote_req_t remote;
   int error_cnt = 0;
   int num_checks = 0;
   serializer_core_control_regs #(.RESET_CYCLES(RST_N)) dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
      .i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_remote(remote), .o_remote_ack(ack),
      .o_remote_rdata(rdata), .i_identity_strap(STRAP_ID), .i_address_strap_pin(strap_volt),
      .i_event_high(i_event_high), .i_event_low(i_event_low), .i_rom_reload_done(i_rom_reload_done),
      .o_rom_reload_start(o_reload), .o_logic_reset(o_logic_reset), .o_bus_identity(o_bus_identity),
      .o_general_cfg(o_general_cfg));
   sercore_host_model host (.i_core_clk(i_core_clk), .i_sda_oe(o_sda_oe), .i_remote_ack(ack),
      .i_remote_rdata(rdata), .o_scl(scl), .o_sda(sda), .o_remote(remote));
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.rem(1'b1, a, d, q);
   endtask
   task automatic rr(input logic [7:0] a);
      host.rem(1'b0, a, 8'h00, q);
   endtask
   // held six cycles; straps are captured a few edges after release
   // the voltage strap pin is set before reset so both levels reach the capture
   task automatic t_reset(input logic v);
      strap_volt = v;
      i_reset = 1'b1;
      cyc(6);
      i_reset = 1'b0;
      cyc(5);
      `CHK("cfg reset", {7'h19, v}, o_general_cfg)
      `CHK("strap id", STRAP_ID, o_bus_identity)
      rr(8'h00);
      `CHK("id reg", {STRAP_ID, 1'b0}, q)
   endtask
   task automatic t_i2c;
      host.i2c_wr(STRAP_ID, 8'h02, 8'h41, ok);
      `CHK("i2c ack", 1'b1, ok)
      `CHK("sda level", 1'b0, o_sda)
      `CHK("cfg i2c", 8'h41, o_general_cfg)
      host.i2c_rd(STRAP_ID, 8'h02, q, ok);
      `CHK("i2c read", 8'h41, q)
      host.i2c_wr(STRAP_ID ^ 7'h01, 8'h02, 8'h00, ok);
      `CHK("foreign ack", 1'b0, ok)
      `CHK("cfg kept", 8'h41, o_general_cfg)
   endtask
   task automatic t_ident;
      wr(8'h00, {7'h51, 1'b1});
      `CHK("id prog", 7'h51, o_bus_identity)
      host.i2c_rd(7'h51, 8'h00, q, ok);
      `CHK("new id read", {7'h51, 1'b1}, q)
      host.i2c_wr(STRAP_ID, 8'h03, 8'h00, ok);
      `CHK("old id ack", 1'b0, ok)
      wr(8'h00, {7'h12, 1'b0});
      `CHK("id strap", STRAP_ID, o_bus_identity)
   endtask
   task automatic t_lanes;
      logic [1:0] c;
      for (int i = 0; i < 3; i++) begin
         c = (i == 2) ? 2'b11 : 2'(i);
         // voltage level changed over the back channel only
         wr(8'h02, {2'b01, c, 4'b0000});
         `CHK("lanes", c, o_general_cfg.data_lane_sel)
         `CHK("crc off", 1'b0, o_general_cfg.crc_tx_enable)
         `CHK("volt", 1'b0, o_general_cfg.bus_voltage_1v8)
      end
   endtask
   task automatic t_soft;
      wr(8'h01, 8'h01);
      `CHK("logic rst", 1'b1, o_logic_reset)
      rr(8'h01);
      `CHK("bit0 busy", 8'h01, q)
      cyc(RST_N + 2);
      rr(8'h01);
      `CHK("bit0 done", 8'h00, q)
      `CHK("cfg kept", 8'h70, o_general_cfg)
      wr(8'h01, 8'h02);
      cyc(RST_N + 2);
      `CHK("cfg full rst", 8'h33, o_general_cfg)
      rr(8'h01);
      `CHK("bit1 done", 8'h00, q)
   endtask
   task automatic t_reload;
      wr(8'h01, 8'h04);
      `CHK("reload start", 1'b1, o_reload)
      cyc(1);
      `CHK("reload pulse", 1'b0, o_reload)
      rr(8'h01);
      `CHK("bit2 busy", 8'h04, q)
      i_rom_reload_done = 1'b1;
      cyc(1);
      i_rom_reload_done = 1'b0;
      cyc(2);
      rr(8'h01);
      `CHK("bit2 done", 8'h00, q)
   endtask
   task automatic t_events;
      i_event_high = 4'h4;
      i_event_low = 4'hD;
      cyc(1);
      i_event_high = 4'h0;
      i_event_low = 4'hF;
      rr(8'hF0);
      `CHK("latched", 8'hD4, q)
      rr(8'hF0);
      `CHK("cleared", 8'hF0, q)
   endtask
   initial begin
      i_rom_reload_done = 1'b0;
      i_event_high = 4'h0;
      i_event_low = 4'hF;
      t_reset(1'b1);
      t_i2c;
      t_ident;
      t_lanes;
      t_soft;
      t_reload;
      t_events;
      t_reset(1'b0);
      end_sim;
   end
   // a hung handshake stops the run
   initial begin
      repeat (30000) @(posedge i_core_clk);
      error_cnt++;
      end_sim;
   end
endmodule
bind serializer_core_control_regs serializer_core_control_regs_asserts #(.RESET_CYCLES(RESET_CYCLES)) chk (
   .i_core_clk, .i_reset, .i_remote, .o_remote_ack, .o_remote_rdata, .o_rom_reload_start, .o_logic_reset,
   .o_bus_identity, .o_general_cfg, .o_sda_oe);
